// ### tlo_pkg.sv
package tlo_pkg;
  // Stuffing modes
  typedef enum logic [1:0] {
    TLO_STUFF_15 = 2'h0,
    TLO_STUFF_80 = 2'h1,
    TLO_STUFF_OFF = 2'h2
  } tlo_stuff_t;
  // Timing sources
  typedef enum logic [1:0] {
    TLO_TS_NETWORK = 2'h0,
    TLO_TS_DSX = 2'h1,
    TLO_TS_INTERNAL = 2'h2,
    TLO_TS_EXTERNAL = 2'h3
  } tlo_tsrc_t;
  // Factory defaults
  localparam logic RST_NET_ESF = 1'h1;
  localparam logic RST_NET_B8ZS = 1'h1;
  localparam tlo_stuff_t RST_STUFF = TLO_STUFF_15;
  localparam logic RST_MGMT = 1'h0;
  localparam logic RST_PRM = 1'h0;
  localparam logic RST_LLB_RESP = 1'h1;
  localparam logic RST_PLB_RESP = 1'h1;
  localparam logic RST_DSX_EN = 1'h1;
  localparam logic RST_DSX_ESF = 1'h1;
  localparam logic RST_DSX_B8ZS = 1'h1;
  localparam logic RST_CONTACT_LB = 1'h0;
  localparam tlo_tsrc_t RST_TSRC = TLO_TS_NETWORK;
  // Ones density
  localparam int ZERO_LIMIT_15 = 15;
  localparam int ZERO_LIMIT_80 = 80;
  localparam int DENS_BLOCK = 24;
  localparam int DENS_ONES = 3;
  // Circuit identifier
  localparam int CID_MAX_LEN = 255;
  // Report period
  localparam int CLK_HZ = 25000000;
  localparam int PRM_PERIOD_MS = 1000;
  localparam int PRM_PERIOD_CYC = CLK_HZ / 1000 * PRM_PERIOD_MS;
endpackage : tlo_pkg

// ### tlo_line_option_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Reset loads every option with its factory default.
// [R2] Network framer runs D4 or extended superframe per framing setting.
// [R3] Network coder uses alternate mark inversion or B8ZS per coding setting.
// [R4] 15-zero mode forces a one after 15 zeros or below 12.5% density.
// [R5] 80-zero mode forces a one once 80 zeros were sent.
// [R6] Stuffing off passes data unchanged.
// [R7] Stuffing acts only with alternate mark inversion coding.
// [R8] Enabled management link carries traffic over the 4 kbps link channel.
// [R9] Management link and reports need extended superframe framing.
// [R10] Management link is off while the port embedded link is on.
// [R11] Remote unit must also enable its link channel.
// [R12] Enabled reports send one report message each second.
// [R13] Line loopback response on: actuate starts if permitted, release ends.
// [R14] Line loopback response off: commands ignored.
// [R15] Line commands come in-band always, bit-oriented only in extended superframe mode.
// [R16] Payload loopback response on: actuate starts if permitted, release ends.
// [R17] Payload loopback response off: commands ignored.
// [R18] Payload loopback response needs extended superframe framing.
// [R19] Circuit identifier holds up to 255 characters; clear empties it.
// [R20] Port disabled hides its options and moves timing off the port.
// [R21] Port line has its own framing and coding selections.
// [R22] Contact loopback on: loopback follows the closed contact.
// [R23] Contact loopback off: contact has no effect.
// [R24] Options made unavailable by dependencies act as inactive.
module tlo_line_option_control #(
  parameter int PRM_CYCLES = tlo_pkg::PRM_PERIOD_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Option load
  input wire logic cfg_load,
  input wire logic cfg_net_esf,
  input wire logic cfg_net_b8zs,
  input wire logic [1:0] cfg_stuff_mode,
  input wire logic cfg_mgmt_en,
  input wire logic cfg_prm_en,
  input wire logic cfg_llb_resp,
  input wire logic cfg_plb_resp,
  input wire logic cfg_dsx_en,
  input wire logic cfg_dsx_esf,
  input wire logic cfg_dsx_b8zs,
  input wire logic cfg_contact_lb,
  input wire logic [1:0] cfg_timing_src,
  input wire logic embedded_port_link,
  // Effective options
  output logic net_framing_esf,
  output logic net_coding_b8zs,
  output logic stuff_active,
  output logic dsx_active,
  output logic dsx_framing_esf,
  output logic dsx_coding_b8zs,
  output logic [1:0] timing_source,
  output logic mgmt_link_active,
  output logic prm_active,
  // Transmit stream
  input wire logic tx_valid,
  input wire logic tx_bit,
  output logic tx_out_valid,
  output logic tx_out_bit,
  // Facility link channel
  input wire logic mgmt_tx_bit,
  input wire logic facility_link_channel_rx,
  output logic facility_link_channel_tx,
  output logic mgmt_rx_bit,
  output logic perf_report_message_send,
  // Loopback commands
  input wire logic llb_inband_act,
  input wire logic llb_inband_rel,
  input wire logic llb_bom_act,
  input wire logic llb_bom_rel,
  input wire logic plb_inband_act,
  input wire logic plb_inband_rel,
  input wire logic plb_bom_act,
  input wire logic plb_bom_rel,
  input wire logic loop_permit,
  input wire logic contact_closed,
  output logic line_loopback,
  output logic payload_loopback,
  output logic local_equipment_loopback,
  // Circuit identifier
  input wire logic cid_wr,
  input wire logic cid_clear,
  input wire logic [7:0] cid_addr,
  input wire logic [7:0] cid_wdata,
  output logic [7:0] cid_rdata,
  output logic [7:0] cid_len
);
  if (PRM_CYCLES < 2) $error("PRM_CYCLES too small");
  logic net_esf_q, net_b8zs_q, mgmt_q, prm_q, llb_resp_q, plb_resp_q;
  logic dsx_en_q, dsx_esf_q, dsx_b8zs_q, contact_lb_q;
  tlo_pkg::tlo_stuff_t stuff_q;
  tlo_pkg::tlo_tsrc_t tsrc_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      net_esf_q <= tlo_pkg::RST_NET_ESF; // R1
      net_b8zs_q <= tlo_pkg::RST_NET_B8ZS;
      stuff_q <= tlo_pkg::RST_STUFF;
      mgmt_q <= tlo_pkg::RST_MGMT;
      prm_q <= tlo_pkg::RST_PRM;
      llb_resp_q <= tlo_pkg::RST_LLB_RESP;
      plb_resp_q <= tlo_pkg::RST_PLB_RESP;
      dsx_en_q <= tlo_pkg::RST_DSX_EN;
      dsx_esf_q <= tlo_pkg::RST_DSX_ESF;
      dsx_b8zs_q <= tlo_pkg::RST_DSX_B8ZS;
      contact_lb_q <= tlo_pkg::RST_CONTACT_LB;
      tsrc_q <= tlo_pkg::RST_TSRC;
    end else begin
      if (cfg_load) begin
        net_esf_q <= cfg_net_esf; // R2
        net_b8zs_q <= cfg_net_b8zs; // R3
        stuff_q <= tlo_pkg::tlo_stuff_t'(cfg_stuff_mode);
        mgmt_q <= cfg_mgmt_en;
        prm_q <= cfg_prm_en;
        llb_resp_q <= cfg_llb_resp;
        plb_resp_q <= cfg_plb_resp;
        dsx_en_q <= cfg_dsx_en;
        dsx_esf_q <= cfg_dsx_esf; // R21
        dsx_b8zs_q <= cfg_dsx_b8zs; // R21
        contact_lb_q <= cfg_contact_lb;
        tsrc_q <= tlo_pkg::tlo_tsrc_t'(cfg_timing_src);
      end else if (!dsx_en_q && tsrc_q == tlo_pkg::TLO_TS_DSX) begin
        tsrc_q <= tlo_pkg::TLO_TS_NETWORK; // R20
      end
    end
  end

  // Effective options
  assign net_framing_esf = net_esf_q; // R2
  assign net_coding_b8zs = net_b8zs_q; // R3
  assign stuff_active = !net_b8zs_q && (stuff_q == tlo_pkg::TLO_STUFF_15 ||
                        stuff_q == tlo_pkg::TLO_STUFF_80); // R7 R24
  assign dsx_active = dsx_en_q;
  assign dsx_framing_esf = dsx_en_q & dsx_esf_q; // R20
  assign dsx_coding_b8zs = dsx_en_q & dsx_b8zs_q; // R20
  assign timing_source = tsrc_q;
  assign mgmt_link_active = mgmt_q & net_esf_q & !embedded_port_link; // R9 R10 R24
  assign prm_active = prm_q & net_esf_q; // R9 R24
  // Ones density enforcement
  logic [6:0] zero_cnt_q;
  logic [4:0] blk_cnt_q;
  logic [1:0] ones_cnt_q;
  logic force_one;
  logic out_bit;
  logic [4:0] left_bits;
  logic [1:0] need_ones;
  always_comb begin
    left_bits = 5'(tlo_pkg::DENS_BLOCK) - blk_cnt_q;
    need_ones = 2'(tlo_pkg::DENS_ONES) - ones_cnt_q;
    force_one = 1'b0;
    if (stuff_active) begin // R7
      unique case (stuff_q)
        tlo_pkg::TLO_STUFF_15: begin
          force_one = zero_cnt_q >= 7'(tlo_pkg::ZERO_LIMIT_15) ||
                      (need_ones != 2'h0 && left_bits <= 5'(need_ones)); // R4
        end
        tlo_pkg::TLO_STUFF_80: begin
          force_one = zero_cnt_q >= 7'(tlo_pkg::ZERO_LIMIT_80); // R5
        end
        default: begin
          force_one = 1'b0; // R6
        end
      endcase
    end
    out_bit = tx_bit | force_one;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_cnt_q <= 7'h00;
      blk_cnt_q <= 5'h00;
      ones_cnt_q <= 2'h0;
    end else if (tx_valid) begin
      zero_cnt_q <= out_bit ? 7'h00 : zero_cnt_q + 7'h01;
      if (blk_cnt_q == 5'(tlo_pkg::DENS_BLOCK - 1)) begin
        blk_cnt_q <= 5'h00;
        ones_cnt_q <= 2'h0;
      end else begin
        blk_cnt_q <= blk_cnt_q + 5'h01;
        if (out_bit && ones_cnt_q != 2'(tlo_pkg::DENS_ONES)) begin
          ones_cnt_q <= ones_cnt_q + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_out_valid <= 1'b0;
      tx_out_bit <= 1'b0;
    end else begin
      tx_out_valid <= tx_valid;
      if (tx_valid) begin
        tx_out_bit <= out_bit; // R4 R5 R6
      end
    end
  end

  // Facility link channel and report timer
  logic [31:0] prm_cnt_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      facility_link_channel_tx <= 1'b0;
      mgmt_rx_bit <= 1'b0;
    end else begin
      facility_link_channel_tx <= mgmt_link_active & mgmt_tx_bit; // R8
      mgmt_rx_bit <= mgmt_link_active & facility_link_channel_rx; // R8 R11
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prm_cnt_q <= 32'h0;
      perf_report_message_send <= 1'b0;
    end else if (!prm_active) begin
      prm_cnt_q <= 32'h0;
      perf_report_message_send <= 1'b0;
    end else if (prm_cnt_q == 32'(PRM_CYCLES - 1)) begin
      prm_cnt_q <= 32'h0;
      perf_report_message_send <= 1'b1; // R12
    end else begin
      prm_cnt_q <= prm_cnt_q + 32'h1;
      perf_report_message_send <= 1'b0;
    end
  end

  // Network loopbacks
  logic llb_act, llb_rel, plb_act, plb_rel, plb_en;
  assign llb_act = llb_inband_act | (net_esf_q & llb_bom_act); // R15
  assign llb_rel = llb_inband_rel | (net_esf_q & llb_bom_rel); // R15
  assign plb_act = plb_inband_act | plb_bom_act;
  assign plb_rel = plb_inband_rel | plb_bom_rel;
  assign plb_en = plb_resp_q & net_esf_q; // R18 R24

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_loopback <= 1'b0;
    end else if (llb_resp_q) begin // R14
      if (llb_rel) begin
        line_loopback <= 1'b0; // R13
      end else if (llb_act && loop_permit) begin
        line_loopback <= 1'b1; // R13
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      payload_loopback <= 1'b0;
    end else if (!net_esf_q) begin
      payload_loopback <= 1'b0; // R18
    end else if (plb_en) begin // R17
      if (plb_rel) begin
        payload_loopback <= 1'b0; // R16
      end else if (plb_act && loop_permit) begin
        payload_loopback <= 1'b1; // R16
      end
    end
  end

  // Contact loopback
  logic contact_s1_q, contact_s2_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      contact_s1_q <= 1'b0;
      contact_s2_q <= 1'b0;
      local_equipment_loopback <= 1'b0;
    end else begin
      contact_s1_q <= contact_closed;
      contact_s2_q <= contact_s1_q;
      local_equipment_loopback <= contact_lb_q & dsx_en_q & contact_s2_q; // R22 R23
    end
  end

  // Circuit identifier store
  logic [7:0] cid_mem [0:tlo_pkg::CID_MAX_LEN-1];
  logic cid_ok;
  assign cid_ok = cid_addr < 8'(tlo_pkg::CID_MAX_LEN);
  always_ff @(posedge sys_clk) begin
    if (cid_wr && cid_ok) begin
      cid_mem[cid_addr] <= cid_wdata;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cid_len <= 8'h00;
      cid_rdata <= 8'h00;
    end else begin
      if (cid_clear) begin
        cid_len <= 8'h00; // R19
      end else if (cid_wr && cid_ok && cid_addr >= cid_len) begin
        cid_len <= cid_addr + 8'h01; // R19
      end
      cid_rdata <= (cid_ok && cid_addr < cid_len) ? cid_mem[cid_addr] : 8'h00;
    end
  end
  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_RST_DEFAULT: assert property ($rose(rst_n) |-> net_esf_q && net_b8zs_q && // R1
    stuff_q == tlo_pkg::TLO_STUFF_15 && !mgmt_q) else $error("defaults wrong after reset");
  AST_B8ZS_NO_STUFF: assert property (tx_valid && net_b8zs_q |=> // R7
    tx_out_bit == $past(tx_bit)) else $error("stuffing applied with B8ZS");
  AST_ZERO_15: assert property (tx_valid && stuff_active && // R4
    stuff_q == tlo_pkg::TLO_STUFF_15 && zero_cnt_q == 7'(tlo_pkg::ZERO_LIMIT_15) |=> tx_out_bit)
    else $error("no one after 15 zeros");
  AST_ZERO_80: assert property (tx_valid && stuff_active && // R5
    stuff_q == tlo_pkg::TLO_STUFF_80 && zero_cnt_q == 7'(tlo_pkg::ZERO_LIMIT_80) |=> tx_out_bit)
    else $error("no one after 80 zeros");
  AST_STUFF_OFF: assert property (tx_valid && stuff_q == tlo_pkg::TLO_STUFF_OFF |=> // R6
    tx_out_bit == $past(tx_bit)) else $error("data changed with stuffing off");
  AST_MGMT_DEP: assert property ((!net_esf_q || embedded_port_link) |=> // R10
    !facility_link_channel_tx) else $error("management link active when unavailable");
  AST_PRM_D4: assert property (!net_esf_q |=> !perf_report_message_send) // R9
    else $error("report sent in D4");
  AST_PRM_GAP: assert property (perf_report_message_send |=> !perf_report_message_send) // R12
    else $error("report pulse too long");
  AST_LLB_IGNORE: assert property (!llb_resp_q |=> $stable(line_loopback)) // R14
    else $error("line loopback moved while ignored");
  AST_LLB_REL: assert property (llb_resp_q && llb_inband_rel |=> !line_loopback) // R13
    else $error("line loopback not released");
  AST_PLB_D4: assert property (!net_esf_q |=> !payload_loopback) // R18
    else $error("payload loopback in D4");
  AST_CONTACT: assert property ((contact_lb_q && dsx_en_q && contact_closed) [*4] |-> // R22
    local_equipment_loopback) else $error("contact loopback not held");
  AST_CONTACT_OFF: assert property (!contact_lb_q |=> !local_equipment_loopback) // R23
    else $error("contact affects loopback while off");
  AST_TSRC: assert property (!dsx_en_q && !cfg_load |=> tsrc_q != tlo_pkg::TLO_TS_DSX) // R20
    else $error("timing left on disabled port");
  AST_CID_CLR: assert property (cid_clear |=> cid_len == 8'h00) // R19
    else $error("identifier not cleared");
  COV_STUFF: cover property (force_one && tx_valid && !tx_bit);
  COV_LLB: cover property ($rose(line_loopback));
  COV_PLB: cover property ($rose(payload_loopback));
  COV_PRM: cover property (perf_report_message_send);
endmodule : tlo_line_option_control

// ### tlo_far_end.sv
`timescale 1ns/1ps
// Remote unit on the link channel: its own link comes up with the local one
module tlo_far_end (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link channel
  input wire logic link_up,
  input wire logic link_tx,
  output logic link_rx
);
  // Bits toggle every cycle, except that once the link is up a high local bit holds them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_rx <= 1'h0;
    end else begin
      link_rx <= link_up ? (~link_rx ^ link_tx) : ~link_rx;
    end
  end
endmodule : tlo_far_end

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int PRM_CYC = 20;
  logic sys_clk, rst_n, cfg_load, cfg_net_esf, cfg_net_b8zs, cfg_mgmt_en, cfg_prm_en, a;
  logic cfg_llb_resp, cfg_plb_resp, cfg_dsx_en, cfg_dsx_esf, cfg_dsx_b8zs, cfg_contact_lb;
  logic embedded_port_link, tx_valid, tx_bit, mgmt_tx_bit, loop_permit, contact_closed;
  logic cid_wr, cid_clear, link_rx, link_tx, perf_report_message_send;
  logic [1:0] cfg_stuff_mode, cfg_timing_src, timing_source;
  logic [7:0] cmds, cid_addr, cid_wdata, cid_rdata, cid_len, ex;
  logic net_framing_esf, net_coding_b8zs, stuff_active, dsx_active, dsx_framing_esf;
  logic dsx_coding_b8zs, mgmt_link_active, prm_active, tx_out_valid, tx_out_bit, mgmt_rx_bit;
  logic line_loopback, payload_loopback, local_equipment_loopback;
  logic exp_q[$];
  int miscompares, compares, zc, pos, ones, n;

  tlo_line_option_control #(.PRM_CYCLES(PRM_CYC)) i_dut (
    .sys_clk, .rst_n, .cfg_load, .cfg_net_esf, .cfg_net_b8zs, .cfg_stuff_mode, .cfg_mgmt_en,
    .cfg_prm_en, .cfg_llb_resp, .cfg_plb_resp, .cfg_dsx_en, .cfg_dsx_esf, .cfg_dsx_b8zs,
    .cfg_contact_lb, .cfg_timing_src, .embedded_port_link, .net_framing_esf, .net_coding_b8zs,
    .stuff_active, .dsx_active, .dsx_framing_esf, .dsx_coding_b8zs, .timing_source,
    .mgmt_link_active, .prm_active, .tx_valid, .tx_bit, .tx_out_valid, .tx_out_bit,
    .mgmt_tx_bit, .facility_link_channel_rx(link_rx), .facility_link_channel_tx(link_tx),
    .mgmt_rx_bit, .perf_report_message_send, .llb_inband_act(cmds[0]),
    .llb_inband_rel(cmds[1]), .llb_bom_act(cmds[2]), .llb_bom_rel(cmds[3]),
    .plb_inband_act(cmds[4]), .plb_inband_rel(cmds[5]), .plb_bom_act(cmds[6]),
    .plb_bom_rel(cmds[7]), .loop_permit, .contact_closed, .line_loopback, .payload_loopback,
    .local_equipment_loopback, .cid_wr, .cid_clear, .cid_addr, .cid_wdata, .cid_rdata, .cid_len
  );
  tlo_far_end i_far (.sys_clk, .rst_n, .link_up(mgmt_link_active), .link_tx, .link_rx);

  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic do_reset();
    rst_n = 1'h0;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'h1;
    {zc, pos, ones} = '0;
  endtask : do_reset

  task automatic ld();
    cfg_load = 1'h1;
    @(negedge sys_clk);
    cfg_load = 1'h0;
    @(negedge sys_clk);
  endtask : ld

  // Stream driver with the stuffing model; the expected bit goes to the queue
  task automatic send(logic b);
    logic o;
    o = b | (!cfg_net_b8zs && ((cfg_stuff_mode == 0 && (zc == 15 ||
        (ones < 3 && 24 - pos == 3 - ones))) || (cfg_stuff_mode == 1 && zc == 80)));
    tx_valid = 1'h1;
    tx_bit = b;
    exp_q.push_back(o);
    zc = o ? 0 : zc + 1;
    ones += o;
    pos = (pos == 23) ? 0 : pos + 1;
    if (pos == 0) ones = 0;
    @(negedge sys_clk);
  endtask : send

  task automatic lbk(int k, logic el, logic ep);
    cmds[k] = 1'h1;
    @(negedge sys_clk);
    cmds = 8'h00;
    @(negedge sys_clk);
    chk("line_loopback", 8'(el), 8'(line_loopback));
    chk("payload_loopback", 8'(ep), 8'(payload_loopback));
  endtask : lbk

  task automatic cw(logic [7:0] ad, logic [7:0] d);
    {cid_wr, cid_addr, cid_wdata} = {1'h1, ad, d};
    @(negedge sys_clk);
    cid_wr = 1'h0;
    @(negedge sys_clk);
  endtask : cw

  task automatic cr(logic [7:0] ad, logic [7:0] e);
    cid_addr = ad;
    repeat (2) @(negedge sys_clk);
    chk("cid_rdata", e, cid_rdata);
  endtask : cr

  // Output watcher: each valid output bit takes the oldest note
  always @(negedge sys_clk) begin
    if (tx_out_valid === 1'h1) begin
      if (exp_q.size() == 0) chk("tx_out_valid", 8'h00, 8'h01);
      else chk("tx_out_bit", 8'(exp_q.pop_front()), 8'(tx_out_bit));
    end
  end

  initial begin
    {cfg_load, tx_valid, tx_bit, mgmt_tx_bit, loop_permit, contact_closed, cid_wr} = '0;
    {cid_clear, embedded_port_link, cfg_mgmt_en, cfg_prm_en, cfg_contact_lb} = '0;
    {cfg_net_esf, cfg_net_b8zs, cfg_llb_resp, cfg_plb_resp, cfg_dsx_en} = '1;
    {cfg_dsx_esf, cfg_dsx_b8zs} = '1;
    {cmds, cid_addr, cid_wdata, cfg_stuff_mode, cfg_timing_src} = '0;
    void'($urandom(36901));
    do_reset();
    chk("options", 8'hDC, {net_framing_esf, net_coding_b8zs, stuff_active, dsx_active,
        dsx_framing_esf, dsx_coding_b8zs, mgmt_link_active, prm_active});
    chk("states", 8'h00, {3'h0, timing_source, line_loopback, payload_loopback,
        local_equipment_loopback});
    chk("cid_len", 8'h00, cid_len);
    {loop_permit, contact_closed} = 2'h3;
    lbk(0, 1, 0);
    lbk(6, 1, 1);
    lbk(7, 1, 0);
    lbk(1, 0, 0);
    chk("local_equipment_loopback", 8'h00, 8'(local_equipment_loopback));
    {loop_permit, contact_closed} = 2'h0;
    $display("test defaults finished");
    for (int k = 0; k < 6; k++) begin
      do_reset();
      cfg_net_b8zs = (k > 3);
      cfg_stuff_mode = 2'(k % 4);
      ld();
      chk("stuff_active", 8'(k < 2), 8'(stuff_active));
      chk("net_coding_b8zs", 8'(k > 3), 8'(net_coding_b8zs));
      for (int i = 0; i < 140; i++) send(i >= 100 && $urandom_range(7) == 0);
      tx_valid = 1'h0;
      repeat (2) @(negedge sys_clk);
      chk("queue_left", 8'h00, 8'(exp_q.size()));
    end
    $display("test stuffing finished");
    for (int k = 0; k < 16; k++) begin
      {cfg_prm_en, cfg_mgmt_en, embedded_port_link, cfg_net_esf} = 4'(k);
      a = k[2] & k[0] & !k[1];
      ld();
      chk("mgmt_link_active", 8'(a), 8'(mgmt_link_active));
      chk("prm_active", 8'(k[3] & k[0]), 8'(prm_active));
      chk("net_framing_esf", 8'(k[0]), 8'(net_framing_esf));
      mgmt_tx_bit = 1'h1;
      ex = {7'h0, link_rx & a};
      @(negedge sys_clk);
      chk("link_tx", 8'(a), 8'(link_tx));
      chk("mgmt_rx_bit", ex, 8'(mgmt_rx_bit));
      mgmt_tx_bit = 1'h0;
    end
    $display("test link finished");
    n = 0;
    while (perf_report_message_send !== 1'h1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (perf_report_message_send !== 1'h1 && n < 100);
    chk("report_period", 8'(PRM_CYC), 8'(n));
    if (n >= 100) conclude();
    $display("test reports finished");
    cfg_net_esf = 1'h1;
    ld();
    lbk(0, 0, 0);
    loop_permit = 1'h1;
    lbk(2, 1, 0);
    lbk(6, 1, 1);
    lbk(3, 0, 1);
    cmds[4] = 1'h1;
    lbk(5, 0, 0);
    lbk(0, 1, 0);
    {cfg_llb_resp, cfg_plb_resp} = 2'h0;
    ld();
    lbk(1, 1, 0);
    lbk(4, 1, 0);
    {cfg_llb_resp, cfg_plb_resp, cfg_net_esf} = 3'h6;
    ld();
    lbk(1, 0, 0);
    lbk(2, 0, 0);
    lbk(4, 0, 0);
    lbk(0, 1, 0);
    $display("test loopbacks finished");
    ex = 8'($urandom);
    cw(8'h00, ex);
    cw(8'h01, 8'h5A);
    chk("cid_len", 8'h02, cid_len);
    cr(8'h00, ex);
    cr(8'h07, 8'h00);
    cw(8'hFE, 8'h41);
    chk("cid_len", 8'hFF, cid_len);
    cw(8'hFF, 8'h42);
    chk("cid_len", 8'hFF, cid_len);
    cid_clear = 1'h1;
    @(negedge sys_clk);
    cid_clear = 1'h0;
    @(negedge sys_clk);
    chk("cid_len", 8'h00, cid_len);
    cr(8'h00, 8'h00);
    $display("test identifier finished");
    {cfg_dsx_en, cfg_dsx_esf, cfg_dsx_b8zs, cfg_timing_src} = 5'h19;
    ld();
    chk("dsx_options", 8'h06, {5'h0, dsx_active, dsx_framing_esf, dsx_coding_b8zs});
    chk("timing_source", 8'h01, {6'h0, timing_source});
    cfg_dsx_en = 1'h0;
    ld();
    chk("dsx_options", 8'h00, {5'h0, dsx_active, dsx_framing_esf, dsx_coding_b8zs});
    chk("timing_source", 8'h00, {6'h0, timing_source});
    cfg_timing_src = 2'h3;
    ld();
    chk("timing_source", 8'h03, {6'h0, timing_source});
    $display("test port finished");
    {cfg_dsx_en, cfg_contact_lb, contact_closed} = 3'h7;
    ld();
    repeat (4) @(negedge sys_clk);
    chk("local_equipment_loopback", 8'h01, 8'(local_equipment_loopback));
    contact_closed = 1'h0;
    repeat (4) @(negedge sys_clk);
    chk("local_equipment_loopback", 8'h00, 8'(local_equipment_loopback));
    cfg_contact_lb = 1'h0;
    ld();
    contact_closed = 1'h1;
    repeat (4) @(negedge sys_clk);
    chk("local_equipment_loopback", 8'h00, 8'(local_equipment_loopback));
    $display("test contact finished");
    conclude();
  end
endmodule : testbench
